// ---- sim/serial_peer.sv ----
// behavioural far-side serial device, msb first
`timescale 1ns/10ps
module serial_peer (
    input wire logic       clk_sys,
    input wire logic       sck,
    input wire logic       dout,
    input wire logic [7:0] tx_byte,
    output logic           din,
    output logic           got,
    output logic [7:0]     got_byte,
    output logic [7:0]     frames
);
    logic       sck_q = 1'b1;
    logic [7:0] cap = 8'h00;
    logic [2:0] nrise = 3'h0;
    logic [2:0] nfall = 3'h0;
    initial begin
        din = 1'b0;
        got = 1'b0;
        got_byte = 8'h00;
        frames = 8'h00;
    end
    always @(posedge clk_sys) begin
        sck_q <= sck;
        got <= 1'b0;
        if (sck && !sck_q) begin // sample on rise
            cap = {cap[6:0], dout};
            if (nrise == 3'h7) begin // eight bits a frame
                got <= 1'b1;
                got_byte <= cap;
                frames <= frames + 8'h01;
                din <= ~din; // released line: no stale level
            end
            nrise = nrise + 3'h1;
        end
        if (!sck && sck_q) begin // answers only clocks it is given
            din <= tx_byte[3'h7 - nfall];
            nfall = nfall + 3'h1;
        end
    end
endmodule : serial_peer

// ---- sim/sync_serial_sva.sv ----
// port-level checks for the synchronous serial core
`timescale 1ns/10ps
module sync_serial_sva (
    input wire logic                        clk_sys,
    input wire logic                        reset_n,
    input wire logic                        clk_en,
    input wire logic [4:0]                  avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [31:0]                 avs_readdata,
    input wire logic                        avs_waitrequest,
    input wire sync_serial_pkg::pin_drive_t data_in_pin,
    input wire sync_serial_pkg::pin_drive_t data_out_pin,
    input wire sync_serial_pkg::pin_drive_t serial_clock_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    a_wait_one: assert property (clk_en && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("more than one wait cycle");
    a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address > sync_serial_pkg::OFS_RX_DATA |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_pin_release: assert property (!(data_in_pin.oe && data_in_pin.to_port)
        && !(data_out_pin.oe && data_out_pin.to_port)
        && !(serial_clock_pin.oe && serial_clock_pin.to_port))
        else $error("pin driven while released");
    a_data_single: assert property (!(data_in_pin.oe && data_out_pin.oe))
        else $error("both data pins driven");
    a_master_din: assert property (serial_clock_pin.oe |-> !data_in_pin.oe)
        else $error("data-in driven as master");
    a_clock_source: assert property ($fell(serial_clock_pin.o) |-> serial_clock_pin.oe)
        else $error("clock pulse without master drive");
    a_half_min: assert property ($changed(serial_clock_pin.o) |=> $stable(serial_clock_pin.o))
        else $error("clock half period under two cycles");
    a_dout_hold: assert property (serial_clock_pin.oe && !serial_clock_pin.o
        && $past(serial_clock_pin.o) == 1'b0 |-> $stable(data_out_pin.o))
        else $error("data-out moved while clock low");
endmodule : sync_serial_sva

bind sync_serial_chip_select_core sync_serial_sva u_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_in_pin(data_in_pin),
    .data_out_pin(data_out_pin), .serial_clock_pin(serial_clock_pin)
);

// ---- sim/tb_top.sv ----
// self-checking bench for the synchronous serial core
`timescale 1ns/10ps
module tb_top;
    logic                        clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [4:0]                  avs_address;
    logic [31:0]                 avs_writedata, avs_readdata;
    logic                        din_w, dout_w, sck_w, got;
    logic [7:0]                  peer_tx, got_byte, frames, b, tgt;
    sync_serial_pkg::pin_drive_t din_p, dout_p, sck_p;
    logic [31:0]                 exp_d[$], exp_m[$];
    logic [7:0]                  exp_s[$];
    int                          failures, compares, cyc;
    assign dout_w = dout_p.o ^ ~dout_p.oe; // undriven line shows the inverse
    assign sck_w = sck_p.oe ? sck_p.o : 1'b1;
    sync_serial_chip_select_core DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .data_in_pin_i(din_p.oe ? din_p.o : din_w),
        .data_in_pin(din_p), .data_out_pin_i(dout_w), .data_out_pin(dout_p),
        .serial_clock_pin_i(sck_w), .serial_clock_pin(sck_p), .irq(irq));
    serial_peer peer (.clk_sys(clk_sys), .sck(sck_w), .dout(dout_w), .tx_byte(peer_tx),
        .din(din_w), .got(got), .got_byte(got_byte), .frames(frames));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic conclude();
        failures += exp_s.size() + exp_d.size(); // unmet notes count as mismatches
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task automatic bus(input logic is_rd, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_read <= is_rd;
        avs_write <= !is_rd;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        do begin // held until waitrequest is sampled low at a rising edge
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_d.push_back(e & m);
        exp_m.push_back(m);
        bus(1'b1, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask : wr
    task automatic frames_to(input logic [7:0] n);
        for (int i = 0; i < 2000 && frames !== n; i++) @(posedge clk_sys);
        repeat (40) @(posedge clk_sys);
    endtask : frames_to
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        compares++;
        if ((g & m) !== e) begin
            failures++;
            $display("ERROR t=%0t read got %h exp %h", $time, g & m, e);
        end
    endtask : cmp_rd
    task automatic cmp_ser(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t serial got %h exp %h", $time, g, e);
        end
    endtask : cmp_ser
    always @(negedge clk_sys) begin // results are settled mid-cycle
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_d.size() > 0)
            cmp_rd(avs_readdata, exp_d.pop_front(), exp_m.pop_front());
        if (got === 1'b1 && exp_s.size() > 0) cmp_ser(got_byte, exp_s.pop_front());
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        {reset_n, avs_read, avs_write, avs_address, avs_writedata, peer_tx} = '0;
        {failures, compares, cyc} = '0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        void'($urandom(32'h91DADFCE));
        rd(sync_serial_pkg::OFS_STATUS, 32'h01, 32'h1F); // empty flag out of reset
        wr(5'h18, 8'hA5);
        rd(5'h18, 32'h0, 32'hFFFFFFFF);
        wr(sync_serial_pkg::OFS_CTRL_HIGH, 8'h01);
        for (int o = 0; o < 2; o++) begin
            wr(sync_serial_pkg::OFS_ENABLE, 8'h00); // quiet before format change
            wr(sync_serial_pkg::OFS_MODE_TWO, o[7:0]);
            wr(sync_serial_pkg::OFS_ENABLE, 8'h01);
            tgt = frames + 8'h02;
            for (int k = 0; k < 2; k++) begin
                b = 8'($urandom);
                exp_s.push_back(o[0] ? {<<{b}} : b);
                wr(sync_serial_pkg::OFS_TX_DATA, b); // second byte mid-frame
            end
            frames_to(tgt);
            rd(sync_serial_pkg::OFS_STATUS, 32'h03, 32'h1F);
        end
        wr(sync_serial_pkg::OFS_ENABLE, 8'h00);
        wr(sync_serial_pkg::OFS_STATUS, 8'h00);
        wr(sync_serial_pkg::OFS_MODE_TWO, 8'h00);
        // divide by 16: synced data-in needs more than a two-cycle half period
        wr(sync_serial_pkg::OFS_CTRL_HIGH, 8'h0B);
        b = 8'($urandom);
        peer_tx <= b;
        wr(sync_serial_pkg::OFS_ENABLE, 8'h12);
        tgt = frames + 8'h01;
        rd(sync_serial_pkg::OFS_RX_DATA, 32'h0, 32'h0); // dummy read starts clock
        frames_to(tgt);
        rd(sync_serial_pkg::OFS_STATUS, 32'h05, 32'h1F); // one byte then halt
        cmp_rd({31'h0, irq}, 32'h1, 32'h1);
        wr(sync_serial_pkg::OFS_ENABLE, 8'h00);
        wr(sync_serial_pkg::OFS_CTRL_HIGH, 8'h09);
        rd(sync_serial_pkg::OFS_RX_DATA, {24'h0, b}, 32'hFF);
        rd(sync_serial_pkg::OFS_STATUS, 32'h01, 32'h1F);
        wr(sync_serial_pkg::OFS_ENABLE, 8'h02);
        tgt = frames + 8'h02;
        rd(sync_serial_pkg::OFS_RX_DATA, 32'h0, 32'h0); // restart burst
        frames_to(tgt);
        rd(sync_serial_pkg::OFS_STATUS, 32'h0D, 32'h1F);
        wr(sync_serial_pkg::OFS_ENABLE, 8'h00);
        rd(sync_serial_pkg::OFS_STATUS, 32'h0D, 32'h1F);
        rd(sync_serial_pkg::OFS_RX_DATA, {24'h0, b}, 32'hFF);
        wr(sync_serial_pkg::OFS_ENABLE, 8'h01);
        wr(sync_serial_pkg::OFS_TX_DATA, 8'h5A);
        repeat (60) @(posedge clk_sys);
        rd(sync_serial_pkg::OFS_STATUS, 32'h08, 32'h1F); // held by overrun
        conclude();
    end
endmodule : tb_top

// ---- src/sync_serial_chip_select_core.sv ----
// synchronous serial port core with avalon register slave
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module sync_serial_chip_select_core (
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    input  wire logic                        clk_en,
    input  wire logic [4:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        data_in_pin_i,
    output sync_serial_pkg::pin_drive_t      data_in_pin,
    input  wire logic                        data_out_pin_i,
    output sync_serial_pkg::pin_drive_t      data_out_pin,
    input  wire logic                        serial_clock_pin_i,
    output sync_serial_pkg::pin_drive_t      serial_clock_pin,
    output logic                             irq
);

    typedef struct packed {
        logic                  ack;
        logic [31:0]           rdata;
        logic                  master_select;
        logic                  single_byte_stop;
        logic [2:0]            div_sel;
        logic                  bit_order_sel;
        logic                  mode_select;
        logic                  bidir_enable;
        logic                  tx_on;
        logic                  rx_on;
        logic                  tx_empty_irq_en;
        logic                  tx_done_irq_en;
        logic                  rx_irq_en;
        logic                  conflict_irq_en;
        logic                  tx_buffer_empty_flag;
        logic                  tx_done_flag;
        logic                  rx_full_flag;
        logic                  overrun_flag;
        logic                  conflict_flag;
        logic [7:0]            tx_data;
        logic [7:0]            rx_data;
        logic [7:0]            shift;
        logic [2:0]            cnt;
        sync_serial_pkg::eng_t fsm;
        logic [7:0]            div;
        logic                  sck;
        logic                  dout;
        logic                  rx_go;
        logic                  sck_s1;
        logic                  sck_s2;
        logic                  sck_s3;
        logic                  din_s1;
        logic                  din_s2;
        logic                  dio_s1;
        logic                  dio_s2;
        logic                  irq;
    } state_t;

    state_t     st_q;
    state_t     st_d;
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // reset released through two flops; assert stays asynchronous
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    function automatic logic out_bit(input logic [7:0] sh, input logic lsb_first);
        out_bit = lsb_first ? sh[0] : sh[7];
    endfunction : out_bit

    // pin roles follow the mode, master and enable bits
    logic use_ssi_in;
    logic use_ssi_out;
    logic use_sso_in;
    logic use_sso_out;
    logic use_sck;
    logic slave_swap;
    logic in_on_sso;

    always_comb begin
        slave_swap  = st_q.mode_select & ~st_q.bidir_enable & ~st_q.master_select;
        in_on_sso   = st_q.mode_select & (st_q.bidir_enable | ~st_q.master_select);
        use_ssi_in  = st_q.rx_on & ~in_on_sso;
        use_sso_in  = st_q.rx_on & in_on_sso;
        use_ssi_out = st_q.tx_on & slave_swap;
        use_sso_out = st_q.tx_on & ~slave_swap;
        use_sck     = st_q.tx_on | st_q.rx_on;
    end

    always_comb begin
        data_in_pin.o            = st_q.dout;
        data_in_pin.oe           = use_ssi_out;
        data_in_pin.to_port      = ~(use_ssi_in | use_ssi_out);
        data_out_pin.o           = st_q.dout;
        data_out_pin.oe          = use_sso_out;
        data_out_pin.to_port     = ~(use_sso_in | use_sso_out);
        serial_clock_pin.o       = st_q.sck;
        serial_clock_pin.oe      = use_sck & st_q.master_select;
        serial_clock_pin.to_port = ~use_sck;
    end

    // a frozen cycle must not complete a transfer the state never took
    assign avs_waitrequest = (avs_read | avs_write) & ~(st_q.ack & clk_en);
    assign avs_readdata    = st_q.rdata;
    assign irq             = st_q.irq;

    always_comb begin
        logic [31:0] rd_mux;
        logic [7:0]  half_m1;
        logic [7:0]  nxt_sh;
        logic        rise;
        logic        fall;
        logic        bit_in;
        logic        ovr;
        logic        wr_en;
        logic        rd_en;

        rd_mux  = 32'h0000_0000;
        half_m1 = 8'((sync_serial_pkg::HALF_BASE << st_q.div_sel) - 8'h01);
        nxt_sh  = 8'h00;
        rise    = 1'b0;
        fall    = 1'b0;
        bit_in  = in_on_sso ? st_q.dio_s2 : st_q.din_s2;
        ovr     = 1'b0;
        wr_en   = st_q.ack & avs_write & avs_byteenable[0];
        rd_en   = st_q.ack & avs_read;

        st_d        = st_q;
        st_d.ack    = 1'b0;
        st_d.sck_s1 = serial_clock_pin_i;
        st_d.sck_s2 = st_q.sck_s1;
        st_d.sck_s3 = st_q.sck_s2;
        st_d.din_s1 = data_in_pin_i;
        st_d.din_s2 = st_q.din_s1;
        st_d.dio_s1 = data_out_pin_i;
        st_d.dio_s2 = st_q.dio_s1;

        case (avs_address)
            sync_serial_pkg::OFS_CTRL_HIGH: begin
                rd_mux[sync_serial_pkg::CTL_MASTER] = st_q.master_select;
                rd_mux[sync_serial_pkg::CTL_SSTOP]  = st_q.single_byte_stop;
                rd_mux[sync_serial_pkg::CTL_DIV_MSB:sync_serial_pkg::CTL_DIV_LSB] = st_q.div_sel;
            end
            sync_serial_pkg::OFS_MODE_TWO: begin
                rd_mux[sync_serial_pkg::MOD_ORDER]  = st_q.bit_order_sel;
                rd_mux[sync_serial_pkg::MOD_SELECT] = st_q.mode_select;
                rd_mux[sync_serial_pkg::MOD_BIDIR]  = st_q.bidir_enable;
            end
            sync_serial_pkg::OFS_ENABLE: begin
                rd_mux[sync_serial_pkg::EN_TX]   = st_q.tx_on;
                rd_mux[sync_serial_pkg::EN_RX]   = st_q.rx_on;
                rd_mux[sync_serial_pkg::EN_TIE]  = st_q.tx_empty_irq_en;
                rd_mux[sync_serial_pkg::EN_TX_DONE_IRQ_EN] = st_q.tx_done_irq_en;
                rd_mux[sync_serial_pkg::EN_RIE]  = st_q.rx_irq_en;
                rd_mux[sync_serial_pkg::EN_CEIE] = st_q.conflict_irq_en;
            end
            sync_serial_pkg::OFS_STATUS: begin
                rd_mux[sync_serial_pkg::ST_TXE]  = st_q.tx_buffer_empty_flag;
                rd_mux[sync_serial_pkg::ST_TX_DONE_FLAG] = st_q.tx_done_flag;
                rd_mux[sync_serial_pkg::ST_RX_FULL_FLAG] = st_q.rx_full_flag;
                rd_mux[sync_serial_pkg::ST_OVERRUN_FLAG] = st_q.overrun_flag;
                rd_mux[sync_serial_pkg::ST_CONF] = st_q.conflict_flag;
            end
            sync_serial_pkg::OFS_TX_DATA: begin
                rd_mux[7:0] = st_q.tx_data;
            end
            sync_serial_pkg::OFS_RX_DATA: begin
                rd_mux[7:0] = st_q.rx_data;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase

        // one wait cycle; read data captured while waitrequest is high
        if ((avs_read | avs_write) & ~st_q.ack) begin
            st_d.ack = 1'b1;
            if (avs_read) begin
                st_d.rdata = rd_mux;
            end
        end

        // register writes; status bits other than the empty flag clear on a written zero
        if (wr_en) begin
            case (avs_address)
                sync_serial_pkg::OFS_CTRL_HIGH: begin
                    st_d.master_select    = avs_writedata[sync_serial_pkg::CTL_MASTER];
                    st_d.single_byte_stop = avs_writedata[sync_serial_pkg::CTL_SSTOP];
                    st_d.div_sel = avs_writedata[sync_serial_pkg::CTL_DIV_MSB:
                                                 sync_serial_pkg::CTL_DIV_LSB];
                end
                sync_serial_pkg::OFS_MODE_TWO: begin
                    st_d.bit_order_sel = avs_writedata[sync_serial_pkg::MOD_ORDER];
                    st_d.mode_select   = avs_writedata[sync_serial_pkg::MOD_SELECT];
                    st_d.bidir_enable  = avs_writedata[sync_serial_pkg::MOD_BIDIR];
                end
                sync_serial_pkg::OFS_ENABLE: begin
                    // flags and receive data are untouched here
                    st_d.tx_on           = avs_writedata[sync_serial_pkg::EN_TX];
                    st_d.rx_on           = avs_writedata[sync_serial_pkg::EN_RX];
                    st_d.tx_empty_irq_en = avs_writedata[sync_serial_pkg::EN_TIE];
                    st_d.tx_done_irq_en  = avs_writedata[sync_serial_pkg::EN_TX_DONE_IRQ_EN];
                    st_d.rx_irq_en       = avs_writedata[sync_serial_pkg::EN_RIE];
                    st_d.conflict_irq_en = avs_writedata[sync_serial_pkg::EN_CEIE];
                end
                sync_serial_pkg::OFS_STATUS: begin
                    st_d.tx_done_flag  = st_q.tx_done_flag &
                                         avs_writedata[sync_serial_pkg::ST_TX_DONE_FLAG];
                    st_d.rx_full_flag  = st_q.rx_full_flag &
                                         avs_writedata[sync_serial_pkg::ST_RX_FULL_FLAG];
                    st_d.overrun_flag  = st_q.overrun_flag &
                                         avs_writedata[sync_serial_pkg::ST_OVERRUN_FLAG];
                    st_d.conflict_flag = st_q.conflict_flag &
                                         avs_writedata[sync_serial_pkg::ST_CONF];
                end
                default: begin
                    st_d.ack = 1'b0;
                end
            endcase
        end

        if (rd_en && avs_address == sync_serial_pkg::OFS_RX_DATA) begin
            st_d.rx_full_flag = 1'b0;
            if (st_q.rx_on) begin
                st_d.rx_go = 1'b1;
            end
        end

        // bit clock events: own divider as master, synced pin as slave
        if (st_q.fsm == sync_serial_pkg::ENG_SHIFT) begin
            if (st_q.master_select) begin
                if (st_q.div == 8'h00) begin
                    st_d.div = half_m1;
                    st_d.sck = ~st_q.sck;
                    rise     = ~st_q.sck;
                    fall     = st_q.sck;
                end else begin
                    st_d.div = st_q.div - 8'h01;
                end
            end else begin
                rise = st_q.sck_s2 & ~st_q.sck_s3;
                fall = ~st_q.sck_s2 & st_q.sck_s3;
            end
        end

        nxt_sh = st_q.bit_order_sel ? {bit_in, st_q.shift[7:1]}
                                    : {st_q.shift[6:0], bit_in};

        case (st_q.fsm)
            sync_serial_pkg::ENG_IDLE: begin
                st_d.sck = sync_serial_pkg::SCK_IDLE;
                st_d.cnt = 3'h0;
                st_d.div = half_m1;
                if (!st_q.overrun_flag) begin
                    if (st_q.tx_on && !st_q.tx_buffer_empty_flag) begin
                        // also starts combined shifting
                        st_d.shift                = st_q.tx_data;
                        st_d.dout                 = out_bit(st_q.tx_data, st_q.bit_order_sel);
                        st_d.tx_buffer_empty_flag = 1'b1;
                        st_d.fsm                  = sync_serial_pkg::ENG_SHIFT;
                    end else if (!st_q.tx_on && st_q.rx_on) begin
                        if (!st_q.master_select || st_q.rx_go) begin
                            st_d.rx_go = 1'b0;
                            st_d.fsm   = sync_serial_pkg::ENG_SHIFT;
                        end
                    end
                end
            end
            sync_serial_pkg::ENG_SHIFT: begin
                if (!(st_q.tx_on || st_q.rx_on)) begin
                    // disabled mid-frame: drop the frame, clock back high
                    st_d.fsm = sync_serial_pkg::ENG_IDLE;
                    st_d.sck = sync_serial_pkg::SCK_IDLE;
                end else if (fall) begin
                    st_d.dout = out_bit(st_q.shift, st_q.bit_order_sel);
                end else if (rise) begin
                    st_d.shift = nxt_sh;
                    st_d.cnt   = st_q.cnt + 3'h1;
                    if (st_q.cnt == sync_serial_pkg::LAST_BIT) begin
                        ovr = st_q.rx_on & st_q.rx_full_flag;
                        if (st_q.rx_on) begin
                            if (st_q.rx_full_flag) begin
                                st_d.overrun_flag = 1'b1;
                            end else begin
                                st_d.rx_data      = nxt_sh;
                                st_d.rx_full_flag = 1'b1;
                            end
                        end
                        if (st_q.tx_on) begin
                            if (!st_q.tx_buffer_empty_flag && !ovr) begin
                                st_d.shift                = st_q.tx_data;
                                st_d.tx_buffer_empty_flag = 1'b1;
                            end else begin
                                st_d.tx_done_flag = st_q.tx_buffer_empty_flag;
                                st_d.fsm          = sync_serial_pkg::ENG_IDLE;
                            end
                        end else if (ovr || (st_q.master_select && st_q.single_byte_stop)) begin
                            st_d.fsm = sync_serial_pkg::ENG_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_d.fsm = sync_serial_pkg::ENG_IDLE;
            end
        endcase

        // a late write wins over the reload of the same cycle
        if (wr_en && avs_address == sync_serial_pkg::OFS_TX_DATA) begin
            st_d.tx_data = avs_writedata[7:0];
            if (st_q.tx_on) begin
                st_d.tx_buffer_empty_flag = 1'b0;
                st_d.tx_done_flag         = 1'b0;
            end
        end

        // one request from five gated sources
        st_d.irq = (st_q.tx_empty_irq_en & st_q.tx_buffer_empty_flag) |
                   (st_q.tx_done_irq_en & st_q.tx_done_flag) |
                   (st_q.rx_irq_en & st_q.rx_full_flag) |
                   (st_q.rx_irq_en & st_q.overrun_flag) |
                   (st_q.conflict_irq_en & st_q.conflict_flag);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q                      <= '0;
            st_q.tx_buffer_empty_flag <= sync_serial_pkg::TXE_RST;
            st_q.sck                  <= sync_serial_pkg::SCK_IDLE;
            st_q.sck_s1               <= sync_serial_pkg::SCK_IDLE;
            st_q.sck_s2               <= sync_serial_pkg::SCK_IDLE;
            st_q.sck_s3               <= sync_serial_pkg::SCK_IDLE;
            st_q.fsm                  <= sync_serial_pkg::ENG_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

endmodule : sync_serial_chip_select_core

// ---- src/sync_serial_pkg.sv ----
// constants and carrier types for the synchronous serial port with chip select
// Contract
// - pin directions from master, transmit, receive enables
// - mode 0 normal roles, mode 1 slave swaps
// - unused serial pins released to port control
// - disabling receive keeps full, overrun, data
// - master drives clock; slave follows external clock
// - transmit write clears empty, moves byte
// - shifting starts when empty sets; empty irq
// - pending byte reloads with no gap
// - eighth bit with empty: done flag, irq
// - serial clock rests high after transmission
// - no transmission while overrun is set
// - master reception starts on dummy data read
// - eight bits stored, full flag, irq
// - reading receive data clears full flag
// - single-byte stop: eight clocks then halt
// - data read with receive on restarts burst
// - eighth edge while full: overrun, stop
// - combined mode starts on transmit write
// - combined stops at end or overrun
// - master clock divided by four to 512
// - bit order: one lsb first, zero msb
// - five gated sources merged into one request
package sync_serial_pkg;
    localparam logic [4:0] OFS_CTRL_HIGH = 5'h00;
    localparam logic [4:0] OFS_MODE_TWO  = 5'h04;
    localparam logic [4:0] OFS_ENABLE    = 5'h08;
    localparam logic [4:0] OFS_STATUS    = 5'h0C;
    localparam logic [4:0] OFS_TX_DATA   = 5'h10;
    localparam logic [4:0] OFS_RX_DATA   = 5'h14;

    localparam int CTL_MASTER  = 0;
    localparam int CTL_SSTOP   = 1;
    localparam int CTL_DIV_LSB = 2;
    localparam int CTL_DIV_MSB = 4;
    localparam int MOD_ORDER   = 0;
    localparam int MOD_SELECT  = 1;
    localparam int MOD_BIDIR   = 2;
    localparam int EN_TX       = 0;
    localparam int EN_RX       = 1;
    localparam int EN_TIE      = 2;
    localparam int EN_TX_DONE_IRQ_EN     = 3;
    localparam int EN_RIE      = 4;
    localparam int EN_CEIE     = 5;
    localparam int ST_TXE      = 0;
    localparam int ST_TX_DONE_FLAG     = 1;
    localparam int ST_RX_FULL_FLAG     = 2;
    localparam int ST_OVERRUN_FLAG     = 3;
    localparam int ST_CONF     = 4;

    localparam logic [7:0] HALF_BASE = 8'h02;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic       TXE_RST   = 1'b1;
    localparam logic       SCK_IDLE  = 1'b1;

    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_SHIFT = 2'b01
    } eng_t;

    typedef struct packed {
        logic o;
        logic oe;
        logic to_port;
    } pin_drive_t;
endpackage : sync_serial_pkg
